// File: core/vfr_pkg.sv
// Constants, field layout and state encoding for the output fault response controller
package vfr_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_VMODE = 8'h20;
    localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
    localparam logic [7:0] CMD_OV_ACTION = 8'h41;
    localparam logic [7:0] CMD_UV_LIMIT = 8'h44;
    localparam logic [7:0] CMD_UV_ACTION = 8'h45;

    // ==========================================================
    // Field positions in the action byte and the mode byte
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    localparam int EXP_HI = 4;
    localparam int EXP_LO = 0;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;

    // ==========================================================
    // Values after reset
    localparam logic [7:0] OV_ACTION_RST = 8'h80;
    localparam logic [7:0] UV_ACTION_RST = 8'h80;
    localparam logic [15:0] OV_LIMIT_RST = 16'hffff;
    localparam logic [15:0] UV_LIMIT_RST = 16'h0000;
    localparam logic [7:0] VMODE_RST = 8'h00;

    // ==========================================================
    // Retry timing
    localparam int RETRY_STEP_MS = 35;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RETRY_STEP_CYC = RETRY_STEP_MS * 1000000 / CLK_PERIOD_NS;

    // ==========================================================
    // Output states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_ON = 2'b01,
        ST_WAIT = 2'b10,
        ST_HOLD = 2'b11
    } vfr_state_e;
endpackage

// File: core/vfr_xfer_if.sv
// Command crossing between the link port and the core
`timescale 1ns/1ps
interface vfr_xfer_if;
    logic req_tgl;
    logic [7:0] code;
    logic write;
    logic word;
    logic [15:0] wdata;
    logic ack_tgl;
    logic [15:0] rdata;
    logic ok;
    modport link (output req_tgl, code, write, word, wdata, input ack_tgl, rdata, ok);
    modport core (input req_tgl, code, write, word, wdata, output ack_tgl, rdata, ok);
endinterface

// File: core/vfr_link_port.sv
// Link clock side: takes commands, hands them to the core by toggle, returns answers
`timescale 1ns/1ps
module vfr_link_port (
    // Clock and reset
    input wire logic lnk_clk,
    input wire logic rstn,
    // Crossing
    vfr_xfer_if.link xf,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    // Answer port
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [15:0] rsp_rdata
);
    logic busy_r, busy_nxt;
    logic req_r, req_nxt;
    logic [7:0] code_r, code_nxt;
    logic wr_r, wr_nxt;
    logic word_r, word_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic ack_s1_r, ack_s2_r, ack_seen_r;
    logic rsp_v_r, rsp_v_nxt;
    logic rsp_ok_r, rsp_ok_nxt;
    logic [15:0] rsp_d_r, rsp_d_nxt;

    assign cmd_ready = ~busy_r;
    assign xf.req_tgl = req_r;
    assign xf.code = code_r;
    assign xf.write = wr_r;
    assign xf.word = word_r;
    assign xf.wdata = wdata_r;
    assign rsp_valid = rsp_v_r;
    assign rsp_ok = rsp_ok_r;
    assign rsp_rdata = rsp_d_r;

    // ==========================================================
    // Next values
    always_comb begin
        busy_nxt = busy_r;
        req_nxt = req_r;
        code_nxt = code_r;
        wr_nxt = wr_r;
        word_nxt = word_r;
        wdata_nxt = wdata_r;
        rsp_v_nxt = 1'b0;
        rsp_ok_nxt = rsp_ok_r;
        rsp_d_nxt = rsp_d_r;
        if (cmd_valid && !busy_r) begin
            busy_nxt = 1'b1;
            req_nxt = ~req_r;
            code_nxt = cmd_code;
            wr_nxt = cmd_write;
            word_nxt = cmd_word;
            wdata_nxt = cmd_wdata;
        end
        if (busy_r && (ack_s2_r != ack_seen_r)) begin
            busy_nxt = 1'b0;
            rsp_v_nxt = 1'b1;
            rsp_ok_nxt = xf.ok;
            rsp_d_nxt = xf.rdata;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge lnk_clk or negedge rstn) begin
        if (!rstn) begin
            busy_r <= 1'b0;
            req_r <= 1'b0;
            code_r <= 8'h00;
            wr_r <= 1'b0;
            word_r <= 1'b0;
            wdata_r <= 16'h0000;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_seen_r <= 1'b0;
            rsp_v_r <= 1'b0;
            rsp_ok_r <= 1'b0;
            rsp_d_r <= 16'h0000;
        end else begin
            busy_r <= busy_nxt;
            req_r <= req_nxt;
            code_r <= code_nxt;
            wr_r <= wr_nxt;
            word_r <= word_nxt;
            wdata_r <= wdata_nxt;
            ack_s1_r <= xf.ack_tgl;
            ack_s2_r <= ack_s1_r;
            ack_seen_r <= ack_s2_r;
            rsp_v_r <= rsp_v_nxt;
            rsp_ok_r <= rsp_ok_nxt;
            rsp_d_r <= rsp_d_nxt;
        end
    end
endmodule // vfr_link_port

// File: core/vfr_fault_ctrl.sv
// Output over/under-voltage fault response controller, core side
// How it works
// - Bits 7:6 of action byte are stored but do not change the response
// - Fault shuts output at once, then retries
// - Any response: alert low, fault flag set
// - Bits 5:3 give number of restart attempts
// - Retry count zero: stay off until cleared
// - Retry count seven: retry without limit
// - Retry wait is (bits 2:0 + 1) steps
// - One step is 35 ms, 35 to 280
// - Under-voltage threshold is 16-bit unsigned word
// - Power good drops below under-voltage threshold
// - Action bytes use byte read and write
// - Under-voltage threshold uses word read/write
// - Over-voltage compares against its own threshold
// - Mode byte bits 4:0 hold exponent
`timescale 1ns/1ps
module vfr_fault_ctrl #(
    parameter int RETRY_STEP_CYC = vfr_pkg::RETRY_STEP_CYC
) (
    // Clocks and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic lnk_clk,
    // Command port, link clock
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_word,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic rsp_ok,
    output logic [15:0] rsp_rdata,
    // Monitor and control, core clock
    input wire logic [15:0] vout_sample,
    input wire logic vout_valid,
    input wire logic other_fault,
    input wire logic clear_faults,
    // Pins
    input wire logic op_on_pin,
    input wire logic bias_ok_pin,
    output logic output_enable,
    output logic output_good_signal,
    output logic alert_line_n,
    output logic alert_line_n_oe,
    // Status
    output logic ov_fault_flag,
    output logic uv_fault_flag,
    output logic [4:0] vout_exponent
);
    import vfr_pkg::*;

    localparam int BW = $clog2(RETRY_STEP_CYC + 1);
    localparam logic [BW-1:0] RELOAD = BW'(RETRY_STEP_CYC - 1);

    generate
        if (RETRY_STEP_CYC < 1 || RETRY_STEP_CYC > 16777216) begin : g_bad
            $error("RETRY_STEP_CYC out of range");
        end
    endgenerate

    // ==========================================================
    // Crossing and link port
    vfr_xfer_if xf ();

    vfr_link_port u_link (
        .lnk_clk(lnk_clk),
        .rstn(rstn),
        .xf(xf),
        .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready),
        .cmd_write(cmd_write),
        .cmd_word(cmd_word),
        .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok),
        .rsp_rdata(rsp_rdata)
    );

    // ==========================================================
    // State
    logic req_s1_r, req_s2_r, req_seen_r;
    logic ack_r, ack_nxt;
    logic ok_r, ok_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic on_s1_r, on_s2_r, bias_s1_r, bias_s2_r;
    logic [7:0] ov_action_r, ov_action_nxt;
    logic [7:0] uv_action_r, uv_action_nxt;
    logic [15:0] ov_limit_r, ov_limit_nxt;
    logic [15:0] uv_limit_r, uv_limit_nxt;
    logic [7:0] vmode_r, vmode_nxt;
    vfr_state_e st_r, st_nxt;
    logic [2:0] budget_r, budget_nxt;
    logic inf_r, inf_nxt;
    logic ctx_r, ctx_nxt;
    logic [2:0] step_r, step_nxt;
    logic [BW-1:0] base_r, base_nxt;
    logic pg_r, pg_nxt;
    logic out_en_r, out_en_nxt;
    logic ov_flag_r, ov_flag_nxt;
    logic uv_flag_r, uv_flag_nxt;
    logic new_req, en_on, ov_hit, uv_hit, hit, restart;
    logic [7:0] sel;

    assign xf.ack_tgl = ack_r;
    assign xf.ok = ok_r;
    assign xf.rdata = rdata_r;
    assign output_enable = out_en_r;
    assign output_good_signal = pg_r;
    assign ov_fault_flag = ov_flag_r;
    assign uv_fault_flag = uv_flag_r;
    assign alert_line_n = ~(ov_flag_r | uv_flag_r);
    assign alert_line_n_oe = ov_flag_r | uv_flag_r;
    assign vout_exponent = vmode_r[EXP_HI:EXP_LO];

    // ==========================================================
    // Fault detection
    assign new_req = req_s2_r != req_seen_r;
    assign en_on = on_s2_r & bias_s2_r;
    assign ov_hit = vout_valid && (vout_sample > ov_limit_r);
    assign uv_hit = vout_valid && pg_r && (vout_sample < uv_limit_r);
    assign hit = ov_hit | uv_hit;
    // Response field is kept but every code disables, then follows the retry field
    assign sel = ov_hit ? ov_action_r : uv_action_r;
    assign restart = (base_r == '0) && (step_r == 3'h0);

    // ==========================================================
    // Next values
    always_comb begin
        ack_nxt = ack_r;
        ok_nxt = ok_r;
        rdata_nxt = rdata_r;
        ov_action_nxt = ov_action_r;
        uv_action_nxt = uv_action_r;
        ov_limit_nxt = ov_limit_r;
        uv_limit_nxt = uv_limit_r;
        vmode_nxt = vmode_r;
        st_nxt = st_r;
        budget_nxt = budget_r;
        inf_nxt = inf_r;
        ctx_nxt = ctx_r;
        step_nxt = step_r;
        base_nxt = base_r;
        pg_nxt = pg_r;
        if (new_req) begin
            ack_nxt = ~ack_r;
            ok_nxt = 1'b0;
            rdata_nxt = 16'h0000;
            case (xf.code)
                CMD_OV_ACTION: begin
                    ok_nxt = ~xf.word;
                    rdata_nxt = {8'h00, ov_action_r};
                    if (xf.write && !xf.word) ov_action_nxt = xf.wdata[7:0];
                end
                CMD_UV_ACTION: begin
                    ok_nxt = ~xf.word;
                    rdata_nxt = {8'h00, uv_action_r};
                    if (xf.write && !xf.word) uv_action_nxt = xf.wdata[7:0];
                end
                CMD_VMODE: begin
                    ok_nxt = ~xf.word;
                    rdata_nxt = {8'h00, vmode_r};
                    if (xf.write && !xf.word) vmode_nxt = xf.wdata[7:0];
                end
                CMD_OV_LIMIT: begin
                    ok_nxt = xf.word;
                    rdata_nxt = ov_limit_r;
                    if (xf.write && xf.word) ov_limit_nxt = xf.wdata;
                end
                CMD_UV_LIMIT: begin
                    ok_nxt = xf.word;
                    rdata_nxt = uv_limit_r;
                    if (xf.write && xf.word) uv_limit_nxt = xf.wdata;
                end
                default: begin
                    ok_nxt = 1'b0;
                end
            endcase
        end
        // Flags: a new fault wins over a clear in the same cycle
        ov_flag_nxt = (ov_flag_r & ~clear_faults) | ((st_r == ST_ON) & ov_hit);
        uv_flag_nxt = (uv_flag_r & ~clear_faults) | ((st_r == ST_ON) & uv_hit);
        if (!en_on) begin
            st_nxt = ST_OFF;
            ctx_nxt = 1'b0;
            budget_nxt = 3'h0;
        end else begin
            case (st_r)
                ST_OFF: begin
                    st_nxt = ST_ON;
                end
                ST_ON: begin
                    if (other_fault) begin
                        st_nxt = ST_HOLD;
                    end else if (hit) begin
                        st_nxt = ST_WAIT;
                        step_nxt = sel[DELAY_HI:DELAY_LO];
                        base_nxt = RELOAD;
                        if (!ctx_r) begin
                            ctx_nxt = 1'b1;
                            budget_nxt = sel[RETRY_HI:RETRY_LO];
                            inf_nxt = sel[RETRY_HI:RETRY_LO] == RETRY_FOREVER;
                            if (sel[RETRY_HI:RETRY_LO] == RETRY_NONE) st_nxt = ST_HOLD;
                        end else if (!inf_r && budget_r == 3'h0) begin
                            st_nxt = ST_HOLD;
                        end
                    end
                end
                ST_WAIT: begin
                    if (other_fault) begin
                        st_nxt = ST_HOLD;
                    end else if (restart) begin
                        st_nxt = ST_ON;
                        if (!inf_r) budget_nxt = budget_r - 3'h1;
                    end else if (base_r == '0) begin
                        step_nxt = step_r - 3'h1;
                        base_nxt = RELOAD;
                    end else begin
                        base_nxt = base_r - BW'(1);
                    end
                end
                ST_HOLD: begin
                    if (clear_faults) begin
                        st_nxt = ST_ON;
                        ctx_nxt = 1'b0;
                    end
                end
                default: begin
                    st_nxt = ST_OFF;
                end
            endcase
        end
        if (st_r == ST_ON && vout_valid) pg_nxt = vout_sample >= uv_limit_r;
        if (st_nxt != ST_ON) pg_nxt = 1'b0;
        out_en_nxt = st_nxt == ST_ON;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_seen_r <= 1'b0;
            ack_r <= 1'b0;
            ok_r <= 1'b0;
            rdata_r <= 16'h0000;
            on_s1_r <= 1'b0;
            on_s2_r <= 1'b0;
            bias_s1_r <= 1'b0;
            bias_s2_r <= 1'b0;
            ov_action_r <= OV_ACTION_RST;
            uv_action_r <= UV_ACTION_RST;
            ov_limit_r <= OV_LIMIT_RST;
            uv_limit_r <= UV_LIMIT_RST;
            vmode_r <= VMODE_RST;
            st_r <= ST_OFF;
            budget_r <= 3'h0;
            inf_r <= 1'b0;
            ctx_r <= 1'b0;
            step_r <= 3'h0;
            base_r <= '0;
            pg_r <= 1'b0;
            out_en_r <= 1'b0;
            ov_flag_r <= 1'b0;
            uv_flag_r <= 1'b0;
        end else begin
            req_s1_r <= xf.req_tgl;
            req_s2_r <= req_s1_r;
            req_seen_r <= req_s2_r;
            ack_r <= ack_nxt;
            ok_r <= ok_nxt;
            rdata_r <= rdata_nxt;
            on_s1_r <= op_on_pin;
            on_s2_r <= on_s1_r;
            bias_s1_r <= bias_ok_pin;
            bias_s2_r <= bias_s1_r;
            ov_action_r <= ov_action_nxt;
            uv_action_r <= uv_action_nxt;
            ov_limit_r <= ov_limit_nxt;
            uv_limit_r <= uv_limit_nxt;
            vmode_r <= vmode_nxt;
            st_r <= st_nxt;
            budget_r <= budget_nxt;
            inf_r <= inf_nxt;
            ctx_r <= ctx_nxt;
            step_r <= step_nxt;
            base_r <= base_nxt;
            pg_r <= pg_nxt;
            out_en_r <= out_en_nxt;
            ov_flag_r <= ov_flag_nxt;
            uv_flag_r <= uv_flag_nxt;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence fault_in_on;
        st_r == ST_ON && en_on && !other_fault && hit;
    endsequence

    output_off_a: assert property (fault_in_on |=> !output_enable ##0 st_r != ST_ON)
        else $error("output not shut off on fault");
    alert_low_a: assert property (fault_in_on |=> !alert_line_n && alert_line_n_oe)
        else $error("alert not driven low on fault");
    ov_flag_a: assert property (st_r == ST_ON && ov_hit |=> ov_flag_r ##1 (ov_flag_r || $past(clear_faults)))
        else $error("over-voltage flag not held");
    no_retry_a: assert property (st_r == ST_ON && en_on && !other_fault && hit && !ctx_r && sel[5:3] == 3'h0
        |=> st_r == ST_HOLD)
        else $error("zero retry count did not hold off");
    forever_a: assert property (st_r == ST_WAIT && inf_r && en_on && !other_fault && restart
        |=> st_r == ST_ON && inf_r && output_enable)
        else $error("unlimited retry stopped");
    budget_a: assert property (st_r == ST_WAIT && !inf_r && en_on && !other_fault && restart
        |=> budget_r == $past(budget_r) - 3'h1)
        else $error("retry budget not decremented");
    delay_load_a: assert property (st_r == ST_ON && en_on && !other_fault && hit && !ctx_r && sel[5:3] != 3'h0
        |=> st_r == ST_WAIT && step_r == $past(sel[2:0]) && base_r == RELOAD)
        else $error("retry delay not loaded");
    pg_drop_a: assert property (st_r == ST_ON && vout_valid && vout_sample < uv_limit_r
        |=> !output_good_signal)
        else $error("power good not dropped");
    byte_wr_a: assert property (new_req && xf.write && !xf.word && xf.code == CMD_UV_ACTION
        |=> uv_action_r == $past(xf.wdata[7:0]) && ok_r)
        else $error("action byte write lost");
    byte_size_a: assert property (new_req && xf.word && xf.code == CMD_OV_ACTION
        |=> !ok_r && ov_action_r == $past(ov_action_r))
        else $error("word access to action byte accepted");
    word_wr_a: assert property (new_req && xf.write && xf.word && xf.code == CMD_UV_LIMIT
        |=> uv_limit_r == $past(xf.wdata) && ok_r)
        else $error("threshold word write lost");

    restart_c: cover property (st_r == ST_WAIT ##1 st_r == ST_ON);
    hold_c: cover property (st_r == ST_ON ##1 st_r == ST_HOLD);
    pg_c: cover property ($rose(pg_r));
    word_c: cover property (new_req && xf.word && xf.write);
endmodule // vfr_fault_ctrl

// File: testbench/vfr_host_model.sv
// Host model issuing register commands on the link clock
`timescale 1ns/1ps
module vfr_host_model (
    // Link clock
    input wire logic lnk_clk,
    // Command port
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic cmd_write,
    output logic cmd_word,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    // Answer port
    input wire logic rsp_valid,
    input wire logic rsp_ok,
    input wire logic [15:0] rsp_rdata
);
    initial begin
        {cmd_valid, cmd_write, cmd_word, cmd_code, cmd_wdata} = '0;
    end

    // ==========================================================
    // One transfer, held until taken, released data inverted
    task automatic xfer(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] d,
                        output logic ok, output logic [15:0] rd);
        int n;
        n = 0;
        @(negedge lnk_clk);
        while (cmd_ready !== 1'b1 && n < 40) begin
            @(negedge lnk_clk);
            n++;
        end
        {cmd_write, cmd_word, cmd_code, cmd_wdata} = {wr, wd, code, d};
        cmd_valid = 1'b1;
        @(posedge lnk_clk);
        @(negedge lnk_clk);
        cmd_valid = 1'b0;
        cmd_code = ~cmd_code;
        cmd_wdata = ~cmd_wdata;
        while (rsp_valid !== 1'b1 && n < 80) begin
            @(negedge lnk_clk);
            n++;
        end
        ok = (n < 80) ? rsp_ok : 1'bx;
        rd = rsp_rdata;
    endtask
endmodule // vfr_host_model

// File: testbench/vfr_fault_ctrl_test.sv
// Self-checking bench for the output fault response controller
`timescale 1ns/1ps
module vfr_fault_ctrl_test;
    import vfr_pkg::*;
    typedef struct {logic wr; logic wd; logic [7:0] code; logic [15:0] d; logic ok; logic [15:0] rd;} vfr_row_s;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic lnk_clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] vout_sample = 16'h4000;
    logic vout_valid = 1'b1;
    logic other_fault = 1'b0;
    logic clear_faults = 1'b0;
    logic op_on_pin = 1'b1;
    logic bias_ok_pin = 1'b1;
    logic cmd_valid, cmd_ready, cmd_write, cmd_word, rsp_valid, rsp_ok;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata;
    logic output_enable, output_good_signal, alert_line_n, alert_line_n_oe, ov_fault_flag, uv_fault_flag;
    logic [4:0] vout_exponent;
    logic ok;
    logic [15:0] rd;
    int n_errors = 0;
    int total_checks = 0;
    vfr_row_s rows[19] = '{
        '{1'b0, 1'b0, 8'h41, 16'h0, 1'b1, 16'h0080}, '{1'b0, 1'b0, 8'h45, 16'h0, 1'b1, 16'h0080},
        '{1'b0, 1'b1, 8'h40, 16'h0, 1'b1, 16'hffff}, '{1'b0, 1'b1, 8'h44, 16'h0, 1'b1, 16'h0000},
        '{1'b0, 1'b0, 8'h20, 16'h0, 1'b1, 16'h0000}, '{1'b1, 1'b0, 8'h41, 16'h00a5, 1'b1, 16'h0},
        '{1'b0, 1'b0, 8'h41, 16'h0, 1'b1, 16'h00a5}, '{1'b1, 1'b0, 8'h45, 16'h005a, 1'b1, 16'h0},
        '{1'b0, 1'b0, 8'h45, 16'h0, 1'b1, 16'h005a}, '{1'b1, 1'b1, 8'h44, 16'h1000, 1'b1, 16'h0},
        '{1'b0, 1'b1, 8'h44, 16'h0, 1'b1, 16'h1000}, '{1'b1, 1'b1, 8'h40, 16'h8000, 1'b1, 16'h0},
        '{1'b0, 1'b1, 8'h40, 16'h0, 1'b1, 16'h8000}, '{1'b1, 1'b0, 8'h20, 16'h001f, 1'b1, 16'h0},
        '{1'b1, 1'b1, 8'h41, 16'hffff, 1'b0, 16'h00a5}, '{1'b1, 1'b0, 8'h44, 16'h00ff, 1'b0, 16'h1000},
        '{1'b0, 1'b0, 8'h44, 16'h0, 1'b0, 16'h1000}, '{1'b1, 1'b0, 8'h33, 16'h0011, 1'b0, 16'h0},
        '{1'b0, 1'b1, 8'h20, 16'h0, 1'b0, 16'h001f}};
    logic [7:0] codes[4] = '{8'h08, 8'h48, 8'hc8, 8'h88};

    always #2 core_clk = ~core_clk;
    initial begin
        #1.3;
        forever #6 lnk_clk = ~lnk_clk;
    end

    // ==========================================================
    // Design and host model
    vfr_fault_ctrl #(.RETRY_STEP_CYC(4)) u_dut (.core_clk(core_clk), .rstn(rstn), .lnk_clk(lnk_clk),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok),
        .rsp_rdata(rsp_rdata), .vout_sample(vout_sample), .vout_valid(vout_valid), .other_fault(other_fault),
        .clear_faults(clear_faults), .op_on_pin(op_on_pin), .bias_ok_pin(bias_ok_pin),
        .output_enable(output_enable), .output_good_signal(output_good_signal), .alert_line_n(alert_line_n),
        .alert_line_n_oe(alert_line_n_oe), .ov_fault_flag(ov_fault_flag), .uv_fault_flag(uv_fault_flag),
        .vout_exponent(vout_exponent));
    vfr_host_model u_host (.lnk_clk(lnk_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_rdata(rsp_rdata));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic set_reg(input logic wd, input logic [7:0] code, input logic [15:0] d);
        u_host.xfer(1'b1, wd, code, d, ok, rd);
        check({15'h0, ok}, 16'h1);
    endtask

    task automatic hit(input logic [15:0] s, input logic ov);
        @(negedge core_clk);
        vout_sample = s;
        @(negedge core_clk);
        vout_sample = 16'h4000;
        check({10'h0, output_enable, alert_line_n, alert_line_n_oe, output_good_signal, ov_fault_flag,
               uv_fault_flag}, {14'h2, ov, ~ov});
    endtask

    task automatic restart(input int lo, input int hi);
        int n;
        n = 1;
        while (output_enable !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check({15'h0, n >= lo && n <= hi}, 16'h1);
    endtask

    task automatic stays_off;
        repeat (40) @(negedge core_clk);
        check({15'h0, output_enable}, 16'h0);
    endtask

    task automatic clear;
        @(negedge core_clk);
        clear_faults = 1'b1;
        @(negedge core_clk);
        clear_faults = 1'b0;
        @(negedge core_clk);
        check({13'h0, ov_fault_flag, uv_fault_flag, alert_line_n}, 16'h1);
        restart(1, 299);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge core_clk);
        check({11'h0, output_enable, alert_line_n, alert_line_n_oe, ov_fault_flag, uv_fault_flag}, 16'h8);
        rstn = 1'b1;
        foreach (rows[i]) begin
            u_host.xfer(rows[i].wr, rows[i].wd, rows[i].code, rows[i].d, ok, rd);
            check({15'h0, ok}, {15'h0, rows[i].ok});
            if (!rows[i].wr || !rows[i].ok)
                check(rd, rows[i].rd);
        end
        check({11'h0, vout_exponent}, 16'h1f);
        check({14'h0, output_enable, output_good_signal}, 16'h3);
        set_reg(1'b0, 8'h41, 16'h008a);
        hit(16'h9000, 1'b1);
        restart(12, 14);
        hit(16'h9000, 1'b1);
        stays_off;
        clear;
        set_reg(1'b0, 8'h45, 16'h0080);
        hit(16'h0800, 1'b0);
        stays_off;
        clear;
        set_reg(1'b0, 8'h41, 16'h00b8);
        repeat (3) begin
            hit(16'h9000, 1'b1);
            restart(4, 6);
        end
        clear;
        @(negedge core_clk);
        other_fault = 1'b1;
        @(negedge core_clk);
        other_fault = 1'b0;
        stays_off;
        clear;
        foreach (codes[i]) begin
            set_reg(1'b0, 8'h41, {8'h0, codes[i]});
            hit(16'h9000, 1'b1);
            restart(4, 6);
            op_on_pin = 1'b0;
            repeat (6) @(negedge core_clk);
            check({15'h0, output_enable}, 16'h0);
            op_on_pin = 1'b1;
            clear;
        end
        bias_ok_pin = 1'b0;
        repeat (6) @(negedge core_clk);
        check({15'h0, output_enable}, 16'h0);
        bias_ok_pin = 1'b1;
        restart(1, 299);
        // Unqualified sample must not trip a fault
        @(negedge core_clk);
        vout_valid = 1'b0;
        vout_sample = 16'h9000;
        @(negedge core_clk);
        check({14'h0, output_enable, ov_fault_flag}, 16'h2);
        vout_valid = 1'b1;
        vout_sample = 16'h4000;
        // Reset in mid-run restores the action byte
        rstn = 1'b0;
        repeat (8) @(negedge core_clk);
        check({11'h0, output_enable, alert_line_n, alert_line_n_oe, ov_fault_flag, uv_fault_flag}, 16'h8);
        rstn = 1'b1;
        u_host.xfer(1'b0, 1'b0, CMD_OV_ACTION, 16'h0000, ok, rd);
        check({15'h0, ok}, 16'h1);
        check(rd, {8'h00, OV_ACTION_RST});
        print_verdict;
    end

    initial begin
        #100us;
        n_errors++;
        print_verdict;
    end
endmodule // vfr_fault_ctrl_test
